// ---- pgsc_core.sv ----
// Purpose: power-good masking and delays, clock lock direction, stack size
// Assumes: events and phase flags come from logic on clk_i; sync pin is async
// Notes: registers reached by command code, write and read strobes
// What this block does
// - assert-low delay: code 0 one period, else 2^N+1
// - release delay, same encoding, separate code
// - eight mask bits; 1 blocks event
// - power-good low when disabled or sequencing/fault
// - ramp-down or fault shutdown bypasses assert delay
// - any unmasked fault counts unless response continues
// - assert and release timers run independently
// - direction: off, drive, follow, auto-detect
// - edge bit 0 falling, 1 rising
// - bad clock lock write flags invalid data
// - auto-detect: high or toggling follows, low drives
// - follow-to-drive under sync fault runs 70 percent
// - stack upper byte and start address read zero
// - stack stop codes 0 to 3 valid only
// - bad stack write flags invalid data
// - stack writes only while conversion disabled
`timescale 1ns/1ps
`default_nettype none
module pgsc_core
    import pgsc_pkg::*;
#(
    parameter int SW_CYCLES = PGSC_SW_CYCLES,
    parameter int SLOW_CYCLES = PGSC_SLOW_CYCLES,
    parameter logic [15:0] GOOD_RESET = PGSC_GOOD_RESET,
    parameter logic [7:0] LOCK_RESET = PGSC_LOCK_RESET,
    parameter logic [3:0] STOP_RESET = PGSC_STOP_RESET
)
(
    input wire logic clk_i,
    input wire logic srst_i,
    // command port from the management bus engine
    input wire logic cmd_wr_i,
    input wire logic cmd_rd_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [15:0] cmd_wdata_i,
    output logic [15:0] rd_data_o,
    output logic rd_valid_o,
    output logic invalid_data_o,
    // converter state
    input wire logic conv_en_i,
    input wire logic turn_on_wait_i,
    input wire logic turn_on_ramp_i,
    input wire logic turn_off_ramp_i,
    input wire logic fault_shutdown_i,
    input wire logic sync_fault_i,
    input wire logic [7:0] event_i,
    input wire logic [7:0] continue_i,
    // power good and sync pin
    output logic power_good_output_o,
    input wire logic sync_pin_i,
    output logic sync_out_o,
    output logic sync_oe_n_o,
    output logic sw_tick_o,
    output logic follow_o
);
    logic [15:0] good_reg; // power_good_control
    logic [7:0] lock_reg; // clock_lock_control
    logic [3:0] stack_last_addr; // phase_stack_control low nibble
    logic sync_m; // first sync stage, read only by sync_s
    logic sync_s; // synchronised pin level
    logic sync_d; // delayed copy for edges
    logic pin_edge; // selected edge of the pin
    logic [15:0] div_cnt; // internal oscillator divider
    logic osc_tick; // internal period pulse
    logic slow_osc; // oscillator slowed to 70 percent
    logic det_busy; // auto-detect window running
    logic det_follow; // auto-detect decision
    logic [3:0] det_periods; // periods left in the window
    logic [3:0] det_edges; // edges seen in the window
    logic conv_d; // conversion enable, previous cycle
    logic follow_eff; // follow the pin this cycle
    logic drive_eff; // drive the pin this cycle
    logic follow_d; // follow_eff, previous cycle
    logic tick; // switching period pulse
    logic [7:0] live; // unmasked, counted events
    logic any_bad; // at least one live event
    logic forced_low; // sequencing or fault holds power good low
    logic bypass; // drop at once without delay
    logic assert_done;
    logic release_done;
    logic next_invalid;
    logic wr_lock_ok;
    logic wr_stack_ok;
    logic [15:0] div_top;

    // pin synchroniser; logic uses the second stage and its delayed copy, not the first
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            sync_m <= 1'b0;
            sync_s <= 1'b0;
            sync_d <= 1'b0;
        end
        else
        begin
            sync_m <= sync_pin_i;
            sync_s <= sync_m;
            sync_d <= sync_s;
        end
    end

    // edge bit picks rising or falling edge of the pin
    always_comb
    begin
        if (lock_reg[PGSC_EDGE_BIT])
            pin_edge = sync_s && !sync_d;
        else
            pin_edge = !sync_s && sync_d;
    end

    // direction decode; auto uses the detected result
    always_comb
    begin
        follow_eff = 1'b0;
        drive_eff = 1'b0;
        case (pgsc_dir_t'(lock_reg[PGSC_DIR_MSB:PGSC_DIR_LSB]))
            PGSC_DIR_OFF:
                follow_eff = 1'b0;
            PGSC_DIR_DRIVE:
                drive_eff = 1'b1;
            PGSC_DIR_FOLLOW:
                follow_eff = 1'b1;
            PGSC_DIR_AUTO:
            begin
                // pin is left alone while the detection window runs
                follow_eff = det_follow && !det_busy;
                drive_eff = !det_follow && !det_busy;
            end
            default:
                follow_eff = 1'b0;
        endcase
    end

    // a follower switched to drive under a sync fault runs slow
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            slow_osc <= 1'b0;
            follow_d <= 1'b0;
        end
        else
        begin
            follow_d <= follow_eff;
            if (follow_d && drive_eff && conv_en_i && sync_fault_i)
                slow_osc <= 1'b1;
            else if (!conv_en_i || !sync_fault_i)
                slow_osc <= 1'b0;
        end
    end

    assign div_top = slow_osc ? 16'(SLOW_CYCLES - 1) : 16'(SW_CYCLES - 1);
    assign osc_tick = (div_cnt == 16'h0000);

    // internal oscillator: one pulse per period, drives the pin in drive mode
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            div_cnt <= 16'h0000;
        else if (osc_tick || div_cnt > div_top)
            div_cnt <= div_top;
        else
            div_cnt <= div_cnt - 16'h0001;
    end

    // switching period source: pin edge when following
    assign tick = follow_eff ? pin_edge : osc_tick;

    // auto-detect sampled when conversion is enabled
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            conv_d <= 1'b0;
            det_busy <= 1'b0;
            det_follow <= 1'b0;
            det_periods <= 4'h0;
            det_edges <= 4'h0;
        end
        else
        begin
            conv_d <= conv_en_i;
            if (conv_en_i && !conv_d && lock_reg[PGSC_DIR_MSB:PGSC_DIR_LSB] == PGSC_DIR_AUTO)
            begin
                det_busy <= 1'b1;
                det_periods <= 4'(PGSC_DET_PERIODS);
                det_edges <= 4'h0;
            end
            else if (det_busy)
            begin
                if (pin_edge && det_edges != 4'hf)
                    det_edges <= det_edges + 4'h1;
                if (osc_tick)
                begin
                    det_periods <= det_periods - 4'h1;
                    if (det_periods == 4'h1)
                    begin
                        // a high pin or enough edges means a master is present
                        det_busy <= 1'b0;
                        det_follow <= sync_s || det_edges >= 4'(PGSC_DET_EDGES);
                    end
                end
            end
        end
    end

    // drive the pin: high for the first half of each period, enable low
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            sync_out_o <= 1'b0;
            sync_oe_n_o <= 1'b1;
            sw_tick_o <= 1'b0;
            follow_o <= 1'b0;
        end
        else
        begin
            sync_oe_n_o <= !drive_eff;
            sync_out_o <= drive_eff && (div_cnt > (div_top >> 1));
            sw_tick_o <= tick;
            follow_o <= follow_eff;
        end
    end

    // mask and response filter on the events
    assign live = event_i & ~good_reg[PGSC_MASK_MSB:0] & ~continue_i;
    assign any_bad = |live;
    assign forced_low = !conv_en_i || turn_on_wait_i || turn_on_ramp_i
        || turn_off_ramp_i || fault_shutdown_i;
    assign bypass = turn_off_ramp_i || fault_shutdown_i;

    // the two delays are armed separately
    pgsc_delay_timer u_assert_timer (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .tick_i(tick),
        .arm_i(any_bad && !forced_low),
        .code_i(good_reg[PGSC_ASSERT_MSB:PGSC_ASSERT_LSB]),
        .done_o(assert_done)
    );

    pgsc_delay_timer u_release_timer (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .tick_i(tick),
        .arm_i(!any_bad && !forced_low),
        .code_i(good_reg[PGSC_RELEASE_MSB:PGSC_RELEASE_LSB]),
        .done_o(release_done)
    );

    // power good: forced low at once, else moved only by a finished timer
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            power_good_output_o <= 1'b0;
        else if (forced_low || bypass)
            power_good_output_o <= 1'b0;
        else if (power_good_output_o && assert_done)
            power_good_output_o <= 1'b0;
        else if (!power_good_output_o && release_done)
            power_good_output_o <= 1'b1;
    end

    // write checks: clock lock fill must be 10000b, stack code 0 to 3
    assign wr_lock_ok = cmd_wdata_i[PGSC_FILL_MSB:0] == PGSC_FILL_VALUE
        && cmd_wdata_i[15:8] == 8'h00;
    assign wr_stack_ok = cmd_wdata_i[15:4] == 12'h000
        && cmd_wdata_i[PGSC_STOP_MSB:0] <= PGSC_STOP_MAX;

    // register writes; conversion enable makes the power-good and stack words read-only, clock lock stays writable
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            good_reg <= GOOD_RESET;
            lock_reg <= LOCK_RESET;
            stack_last_addr <= STOP_RESET;
        end
        else if (cmd_wr_i)
        begin
            if (cmd_code_i == PGSC_CMD_GOOD && !conv_en_i)
                good_reg <= cmd_wdata_i;
            if (cmd_code_i == PGSC_CMD_LOCK && wr_lock_ok)
                lock_reg <= cmd_wdata_i[7:0];
            if (cmd_code_i == PGSC_CMD_STACK && wr_stack_ok && !conv_en_i)
                stack_last_addr <= cmd_wdata_i[PGSC_STOP_MSB:0];
        end
    end

    // invalid data report for rejected writes
    always_comb
    begin
        next_invalid = 1'b0;
        if (cmd_wr_i)
        begin
            case (cmd_code_i)
                PGSC_CMD_GOOD:
                    next_invalid = conv_en_i;
                PGSC_CMD_LOCK:
                    next_invalid = !wr_lock_ok;
                PGSC_CMD_STACK:
                    next_invalid = !wr_stack_ok || conv_en_i;
                default:
                    next_invalid = 1'b0;
            endcase
        end
    end

    // one-cycle flag toward the status logic that alerts the host
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            invalid_data_o <= 1'b0;
        else
            invalid_data_o <= next_invalid;
    end

    // read path: answer one cycle after the strobe, unknown codes read zero
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            rd_data_o <= 16'h0000;
            rd_valid_o <= 1'b0;
        end
        else
        begin
            rd_valid_o <= cmd_rd_i;
            if (cmd_rd_i)
            begin
                case (cmd_code_i)
                    PGSC_CMD_GOOD:
                        rd_data_o <= good_reg;
                    PGSC_CMD_LOCK:
                        rd_data_o <= {8'h00, lock_reg};
                    PGSC_CMD_STACK:
                        rd_data_o <= {12'h000, stack_last_addr};
                    default:
                        rd_data_o <= 16'h0000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ---- pgsc_pkg.sv ----
// Purpose: shared constants for the power-good, clock lock and stack block
// Assumes: 200 MHz core clock, switching rate set by a divider
// Notes: command codes are the management bus command bytes
package pgsc_pkg;
    // command codes
    localparam logic [7:0] PGSC_CMD_GOOD = 8'he3;
    localparam logic [7:0] PGSC_CMD_LOCK = 8'he4;
    localparam logic [7:0] PGSC_CMD_STACK = 8'hec;
    // power_good_control fields
    localparam int PGSC_ASSERT_MSB = 15;
    localparam int PGSC_ASSERT_LSB = 12;
    localparam int PGSC_RELEASE_MSB = 11;
    localparam int PGSC_RELEASE_LSB = 8;
    localparam int PGSC_MASK_MSB = 7;
    localparam logic [15:0] PGSC_GOOD_RESET = 16'h0000;
    // clock_lock_control fields
    localparam int PGSC_DIR_MSB = 7;
    localparam int PGSC_DIR_LSB = 6;
    localparam int PGSC_EDGE_BIT = 5;
    localparam int PGSC_FILL_MSB = 4;
    localparam logic [4:0] PGSC_FILL_VALUE = 5'h10;
    localparam logic [7:0] PGSC_LOCK_RESET = 8'h10;
    // phase_stack_control fields
    localparam int PGSC_STOP_MSB = 3;
    localparam logic [3:0] PGSC_STOP_MAX = 4'h3;
    localparam logic [3:0] PGSC_STOP_RESET = 4'h0;
    // timing: switching rate and core clock
    localparam int PGSC_CLK_KHZ = 200000;
    localparam int PGSC_SW_KHZ = 500;
    localparam int PGSC_SW_CYCLES = PGSC_CLK_KHZ / PGSC_SW_KHZ;
    // slowed oscillator runs at 70 percent of nominal
    localparam int PGSC_SLOW_PCT = 70;
    localparam int PGSC_SLOW_CYCLES = (PGSC_SW_CYCLES * 100) / PGSC_SLOW_PCT;
    // auto-detect window in switching periods and 75 percent edge threshold
    localparam int PGSC_DET_PERIODS = 4;
    localparam int PGSC_DET_EDGES = (PGSC_DET_PERIODS * 75 + 99) / 100;
    // clock direction codes
    typedef enum logic [1:0] {
        PGSC_DIR_OFF = 2'b00,
        PGSC_DIR_DRIVE = 2'b01,
        PGSC_DIR_FOLLOW = 2'b10,
        PGSC_DIR_AUTO = 2'b11
    } pgsc_dir_t;
endpackage

// ---- pgsc_delay_timer.sv ----
// Purpose: one power-good delay timer counted in switching periods
// Assumes: tick_i is a one-cycle switching period pulse
// Notes: code 0 gives one period, code n gives 2^n+1 periods
`timescale 1ns/1ps
`default_nettype none
module pgsc_delay_timer
    import pgsc_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic tick_i,
    input wire logic arm_i,
    input wire logic [3:0] code_i,
    output logic done_o
);
    logic [16:0] count; // periods seen while armed
    logic [16:0] target; // terminal count from the code

    // decode the 4-bit code into a period count
    always_comb
    begin
        if (code_i == 4'h0)
            target = 17'h00001;
        else
            target = (17'h00001 << code_i) + 17'h00001;
    end

    // count while armed, restart as soon as the condition drops
    always_ff @(posedge clk_i)
    begin
        if (srst_i || !arm_i)
        begin
            count <= 17'h00000;
            done_o <= 1'b0;
        end
        else if (tick_i && !done_o)
        begin
            count <= count + 17'h00001;
            done_o <= (count + 17'h00001) >= target;
        end
    end
endmodule
`default_nettype wire

// ---- pgsc_core_assertions.sv ----
// Purpose: port checks for pgsc_core
// Assumes: one clock, synchronous active high reset
// Notes: bound to every pgsc_core instance
`timescale 1ns/1ps
`default_nettype none
module pgsc_core_checker
    import pgsc_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic cmd_wr_i,
    input wire logic cmd_rd_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [15:0] cmd_wdata_i,
    input wire logic [15:0] rd_data_o,
    input wire logic rd_valid_o,
    input wire logic invalid_data_o,
    input wire logic conv_en_i,
    input wire logic turn_on_wait_i,
    input wire logic turn_on_ramp_i,
    input wire logic turn_off_ramp_i,
    input wire logic fault_shutdown_i,
    input wire logic [7:0] event_i,
    input wire logic [7:0] continue_i,
    input wire logic power_good_output_o,
    input wire logic sync_oe_n_o,
    input wire logic follow_o
);
    // any phase that must hold power good low
    logic forced;
    // live event that may pull power good low
    logic live;
    // write aimed at the stack register
    logic stack_wr;
    assign forced = !conv_en_i || turn_on_wait_i || turn_on_ramp_i || turn_off_ramp_i || fault_shutdown_i;
    assign live = (event_i & ~continue_i) != 8'h00;
    assign stack_wr = cmd_wr_i && cmd_code_i == PGSC_CMD_STACK;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    a_forced_low: assert property (forced |=> !power_good_output_o)
        else $error("power good high while forced");
    // a fall needs a cause in the last two cycles
    a_fall_cause: assert property ($fell(power_good_output_o) |->
        $past(forced) || $past(live) || $past(forced, 2) || $past(live, 2))
        else $error("power good fell without cause");
    a_read_answer: assert property (cmd_rd_i |=> rd_valid_o)
        else $error("read not answered");
    // power good may only rise after a cycle with nothing forcing it low
    a_rise_free: assert property ($rose(power_good_output_o) |-> !$past(forced))
        else $error("power good rose while forced");
    // a refusal flag only ever follows a write strobe
    a_invalid_cause: assert property (invalid_data_o |-> $past(cmd_wr_i))
        else $error("invalid data without a write");
    a_stack_upper: assert property (rd_valid_o && $past(cmd_code_i) == PGSC_CMD_STACK |->
        rd_data_o[15:4] == 12'h000)
        else $error("stack upper bits not zero");
    a_stack_range: assert property (stack_wr && cmd_wdata_i[3:0] > PGSC_STOP_MAX |=> invalid_data_o)
        else $error("bad stack code accepted");
    a_stack_busy: assert property (stack_wr && conv_en_i |=> invalid_data_o)
        else $error("stack write accepted while enabled");
    a_stack_ok: assert property (stack_wr && !conv_en_i && cmd_wdata_i[15:4] == 12'h000 &&
        cmd_wdata_i[3:0] <= PGSC_STOP_MAX |=> !invalid_data_o)
        else $error("good stack code refused");
    a_lock_fill: assert property (cmd_wr_i && cmd_code_i == PGSC_CMD_LOCK &&
        cmd_wdata_i[4:0] != PGSC_FILL_VALUE |=> invalid_data_o)
        else $error("bad lock filler accepted");
    a_drive_follow: assert property (!sync_oe_n_o |-> !follow_o)
        else $error("driving and following at once");
endmodule
bind pgsc_core pgsc_core_checker u_chk (.clk_i, .srst_i, .cmd_wr_i, .cmd_rd_i, .cmd_code_i, .cmd_wdata_i,
    .rd_data_o, .rd_valid_o, .invalid_data_o, .conv_en_i, .turn_on_wait_i, .turn_on_ramp_i, .turn_off_ramp_i,
    .fault_shutdown_i, .event_i, .continue_i, .power_good_output_o, .sync_oe_n_o, .follow_o);
`default_nettype wire

// ---- pgsc_host_model.sv ----
// Purpose: management bus host seen through the command port
// Assumes: strobes change only on the falling edge
// Notes: released code and data lines show the inverse value
`timescale 1ns/1ps
`default_nettype none
module pgsc_host_model
    import pgsc_pkg::*;
(
    input wire logic clk_i,
    output logic cmd_wr_o,
    output logic cmd_rd_o,
    output logic [7:0] cmd_code_o,
    output logic [15:0] cmd_wdata_o,
    input wire logic [15:0] rd_data_i,
    input wire logic rd_valid_i,
    input wire logic invalid_data_i
);
    // idle port at time zero
    initial
    begin
        cmd_wr_o = 1'b0;
        cmd_rd_o = 1'b0;
        cmd_code_o = 8'h00;
        cmd_wdata_o = 16'h0000;
    end
    // one-cycle write; refusal flag is taken one cycle after the strobe
    task automatic wr(input logic [7:0] code, input logic [15:0] data, output logic inv);
        @(negedge clk_i);
        cmd_wr_o = 1'b1;
        cmd_code_o = code;
        cmd_wdata_o = data;
        @(negedge clk_i);
        cmd_wr_o = 1'b0;
        cmd_code_o = ~code;
        cmd_wdata_o = ~data;
        inv = invalid_data_i;
    endtask
    // one-cycle read; data and valid are taken together
    task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic ok);
        @(negedge clk_i);
        cmd_rd_o = 1'b1;
        cmd_code_o = code;
        @(negedge clk_i);
        cmd_rd_o = 1'b0;
        cmd_code_o = ~code;
        data = rd_data_i;
        ok = rd_valid_i;
    endtask
    // lock writes through this task always carry the fixed filler
    task automatic wr_lock(input logic [1:0] dir, input logic edge_sel, output logic inv);
        wr(PGSC_CMD_LOCK, {8'h00, dir, edge_sel, PGSC_FILL_VALUE}, inv);
    endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Purpose: self-checking bench for pgsc_core
// Assumes: switching period shortened to 8 clocks
// Notes: host model drives the command port
`timescale 1ns/1ps
`default_nettype none
module testbench
    import pgsc_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    logic conv_en = 1'b0;
    logic [3:0] phase = 4'h0; // wait, ramp up, ramp down, fault
    logic [7:0] evt = 8'h00;
    logic [7:0] cont = 8'h00;
    logic sync_pin = 1'b0;
    logic sync_fault = 1'b0; // lock lost while conversion is enabled
    logic cmd_wr, cmd_rd, rd_valid, inv_flag, pg, sync_out, oe_n, tick, follow;
    logic [7:0] cmd_code;
    logic [15:0] wdata, rd_data;
    always #2.5 clk = ~clk;
    pgsc_host_model u_host (.clk_i(clk), .cmd_wr_o(cmd_wr), .cmd_rd_o(cmd_rd), .cmd_code_o(cmd_code),
        .cmd_wdata_o(wdata), .rd_data_i(rd_data), .rd_valid_i(rd_valid), .invalid_data_i(inv_flag));
    pgsc_core #(.SW_CYCLES(8), .SLOW_CYCLES(11)) dut (.clk_i(clk), .srst_i(srst), .cmd_wr_i(cmd_wr),
        .cmd_rd_i(cmd_rd), .cmd_code_i(cmd_code), .cmd_wdata_i(wdata), .rd_data_o(rd_data),
        .rd_valid_o(rd_valid), .invalid_data_o(inv_flag), .conv_en_i(conv_en), .turn_on_wait_i(phase[3]),
        .turn_on_ramp_i(phase[2]), .turn_off_ramp_i(phase[1]), .fault_shutdown_i(phase[0]),
        .sync_fault_i(sync_fault), .event_i(evt), .continue_i(cont), .power_good_output_o(pg),
        .sync_pin_i(sync_pin), .sync_out_o(sync_out), .sync_oe_n_o(oe_n), .sw_tick_o(tick), .follow_o(follow));
    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // bounded wait for a power good level
    task automatic wait_pg(input logic v, input int lim, output int n);
        n = 0;
        while (pg !== v && n < lim)
        begin
            @(negedge clk);
            n++;
        end
    endtask
    // flags any dip of power good over a span
    task automatic hold_high(input int cyc, output logic bad);
        bad = 1'b0;
        repeat (cyc)
        begin
            @(negedge clk);
            if (pg !== 1'b1)
                bad = 1'b1;
        end
    endtask
    // counts switching pulses and driven-high pin cycles over a span
    task automatic count_ticks(input int cyc, output int n, output int h);
        n = 0;
        h = 0;
        repeat (cyc)
        begin
            @(negedge clk);
            if (tick === 1'b1)
                n++;
            if (sync_out === 1'b1)
                h++;
        end
    endtask
    task automatic t_regs();
        logic [15:0] d;
        logic v;
        u_host.rd(PGSC_CMD_GOOD, d, v);
        chk(d, 16'h0000);
        u_host.rd(PGSC_CMD_LOCK, d, v);
        chk(d, 16'h0010);
        u_host.rd(8'h00, d, v);
        chk({d[14:0], v}, 16'h0001);
    endtask
    task automatic t_stack();
        logic f;
        logic v;
        logic [15:0] d;
        for (int i = 0; i < 5; i++)
        begin
            u_host.wr(PGSC_CMD_STACK, 16'(i), f);
            chk(16'(f), 16'(i > 3));
            u_host.rd(PGSC_CMD_STACK, d, v);
            chk(d, (i > 3) ? 16'h0003 : 16'(i));
        end
        u_host.wr(PGSC_CMD_STACK, 16'h0011, f);
        chk(16'(f), 16'h0001);
        conv_en = 1'b1;
        u_host.wr(PGSC_CMD_STACK, 16'h0001, f);
        chk(16'(f), 16'h0001);
        u_host.rd(PGSC_CMD_STACK, d, v);
        chk(d, 16'h0003);
        conv_en = 1'b0;
    endtask
    task automatic t_lock();
        logic f;
        logic v;
        logic [15:0] d;
        for (int i = 0; i < 8; i++)
        begin
            u_host.wr_lock(2'(i >> 1), i[0], f);
            u_host.rd(PGSC_CMD_LOCK, d, v);
            chk(d, {8'h00, 2'(i >> 1), i[0], 5'h10});
        end
        u_host.wr(PGSC_CMD_LOCK, 16'h00c0, f);
        u_host.rd(PGSC_CMD_LOCK, d, v);
        chk({d[14:0], f}, 16'h01e1);
        u_host.wr_lock(2'b01, 1'b0, f);
        repeat (4) @(negedge clk);
        chk(16'(oe_n), 16'h0000);
        u_host.wr_lock(2'b00, 1'b0, f);
        repeat (4) @(negedge clk);
        chk(16'(oe_n), 16'h0001);
    endtask
    // auto-detect: pin held high then static low at enable
    task automatic t_auto();
        logic f;
        for (int p = 1; p >= 0; p--)
        begin
            conv_en = 1'b0;
            sync_pin = p[0];
            u_host.wr_lock(2'b11, 1'b0, f);
            conv_en = 1'b1;
            repeat (48) @(negedge clk);
            chk({15'h0000, follow}, 16'(p));
            chk({15'h0000, oe_n}, 16'(p));
        end
        conv_en = 1'b0;
    endtask
    task automatic t_good();
        logic f;
        int n;
        int t;
        for (int c = 0; c < 3; c++)
        begin
            t = (c == 0) ? 1 : (1 << c) + 1;
            conv_en = 1'b0;
            u_host.wr(PGSC_CMD_GOOD, {4'(c), 4'h0, 8'h80}, f);
            conv_en = 1'b1;
            wait_pg(1'b1, 40, n);
            chk({15'h0000, pg}, 16'h0001);
            evt = 8'h80;
            hold_high(40, f);
            chk(16'(f), 16'h0000);
            evt = 8'h01;
            cont = 8'h01;
            hold_high(40, f);
            chk(16'(f), 16'h0000);
            cont = 8'h00;
            wait_pg(1'b0, 80, n);
            chk(16'(n >= (t - 1) * 8 && n <= t * 8 + 4), 16'h0001);
            evt = 8'h00;
            wait_pg(1'b1, 80, n);
            chk(16'(n <= 12), 16'h0001);
        end
        // short event under the delay difference leaves power good up
        evt = 8'h01;
        repeat (16) @(negedge clk);
        evt = 8'h00;
        hold_high(40, f);
        chk(16'(f), 16'h0000);
        for (int k = 0; k < 4; k++)
        begin
            phase = 4'(1 << k);
            wait_pg(1'b0, 2, n);
            chk({15'h0000, pg}, 16'h0000);
            phase = 4'h0;
            wait_pg(1'b1, 40, n);
        end
        conv_en = 1'b0;
        wait_pg(1'b0, 2, n);
        chk({15'h0000, pg}, 16'h0000);
    endtask
    // followed pin edge choice, then a follow-to-drive change under a sync fault
    task automatic t_sync();
        logic f;
        int n;
        int h;
        sync_pin = 1'b0;
        for (int e = 0; e < 2; e++)
        begin
            u_host.wr_lock(2'b10, e[0], f);
            // pin edge reaches the pulse output three clocks later
            sync_pin = 1'b1;
            repeat (3) @(negedge clk);
            chk(16'(tick), 16'(e));
            sync_pin = 1'b0;
            repeat (3) @(negedge clk);
            chk(16'(tick), 16'(1 - e));
        end
        conv_en = 1'b1;
        sync_fault = 1'b1;
        repeat (2) @(negedge clk);
        u_host.wr_lock(2'b01, 1'b0, f);
        repeat (24) @(negedge clk);
        // 44 clocks hold exactly four slowed periods of 11
        count_ticks(44, n, h);
        chk(16'(n), 16'h0004);
        sync_fault = 1'b0;
        repeat (16) @(negedge clk);
        // nominal period of 8: five pulses, pin high half of each period
        count_ticks(40, n, h);
        chk(16'(n), 16'h0005);
        chk(16'(h), 16'h0014);
        conv_en = 1'b0;
    endtask
    task automatic results();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // hang guard well above the expected run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            results();
        end
    end
    initial
    begin
        repeat (20) @(negedge clk);
        srst = 1'b0;
        t_regs();
        t_stack();
        t_lock();
        t_auto();
        t_good();
        t_sync();
        results();
    end
endmodule
`default_nettype wire
